// File: hdl/bst_map.svh
`ifndef BST_MAP_SVH
`define BST_MAP_SVH
// Instruction register
`define BST_IR_LEN 10
`define BST_IR_CAPTURE 10'h001
`define BST_OP_EXTEST 10'h000
`define BST_OP_SAMPLE 10'h055
`define BST_OP_IDCODE 10'h059
`define BST_OP_USIG 10'h079
`define BST_OP_BYPASS 10'h3FF
`define BST_OP_ISP_ENTER 10'h202
`define BST_OP_ISP_EXIT 10'h203
`define BST_OP_ISP_ADDR 10'h204
`define BST_OP_ISP_DATA 10'h205
// Data register lengths
`define BST_ID_LEN 32
`define BST_USIG_LEN 16
`define BST_BSR_MIN 504
`define BST_BSR_LONGEST 648
// Identification word field widths, top to bottom
`define BST_ID_VER_W 4
`define BST_ID_PART_W 16
`define BST_ID_MFR_W 11
`endif

// File: hdl/bst_pkg.sv
package bst_pkg;
    // Sixteen test access port states, one-hot
    typedef enum logic [15:0] {
        BST_TLR = 16'h0001, BST_RTI = 16'h0002, BST_SEL_DR = 16'h0004, BST_CAP_DR = 16'h0008,
        BST_SH_DR = 16'h0010, BST_EX1_DR = 16'h0020, BST_PA_DR = 16'h0040, BST_EX2_DR = 16'h0080,
        BST_UP_DR = 16'h0100, BST_SEL_IR = 16'h0200, BST_CAP_IR = 16'h0400, BST_SH_IR = 16'h0800,
        BST_EX1_IR = 16'h1000, BST_PA_IR = 16'h2000, BST_EX2_IR = 16'h4000, BST_UP_IR = 16'h8000
    } bst_tap_state_type;
    // Data register currently between serial input and output
    typedef enum logic [5:0] {
        BST_DR_BYP = 6'h01, BST_DR_ID = 6'h02, BST_DR_USIG = 6'h04,
        BST_DR_BSR = 6'h08, BST_DR_ADDR = 6'h10, BST_DR_DATA = 6'h20
    } bst_dr_sel_type;
endpackage : bst_pkg

// File: hdl/bst_test_port.sv
`timescale 1ns/1ps
`include "bst_map.svh"
// Behaviour
// - Sample/preload captures pins, preloads pattern.
// - Extest drives outputs, captures input pins.
// - Bypass puts one-bit stage in path.
// - Identification instruction shifts 32-bit word out.
// - User-signature instruction shifts signature out.
// - User signature register is sixteen bits.
// - Instruction register is ten bits.
// - Boundary register length fixed per variant.
// - Identification word: version, part, maker, one.
// - Identification word LSB always one.
// - Disabled port releases pins as user I/O.
// - Accept in-system programming instruction group.
// - Programming shifts address/data, returns read data.
module bst_test_port import bst_pkg::*; #(
    parameter int BSR_LEN = 504,
    parameter int ISP_AW = 16,
    parameter int ISP_DW = 16,
    parameter bit HAS_IDCODE = 1'b1,
    parameter bit HAS_USIG = 1'b1,
    parameter logic [3:0] ID_VERSION = 4'h1, // Arbitrary value
    parameter logic [15:0] ID_PART = 16'h5A3C, // Arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h2B5 // Arbitrary value
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic port_en,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_o,
    output logic tdo_oe,
    output logic [2:0] user_pin_in,
    input wire logic user_tdo_o,
    input wire logic user_tdo_oe,
    input wire logic [BSR_LEN-1:0] pin_in,
    input wire logic [BSR_LEN-1:0] core_out,
    output logic [BSR_LEN-1:0] pin_out,
    input wire logic [`BST_USIG_LEN-1:0] user_signature,
    output logic isp_mode,
    output logic [ISP_AW-1:0] isp_addr,
    output logic [ISP_DW-1:0] isp_wdata,
    output logic isp_write,
    input wire logic [ISP_DW-1:0] isp_rdata
);
    localparam int IRL = `BST_IR_LEN;
    localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    localparam logic [IRL-1:0] IR_DEF = HAS_IDCODE ? `BST_OP_IDCODE : `BST_OP_BYPASS;

    // Shared data shift register must hold the longest chain
    if (BSR_LEN < `BST_BSR_MIN || BSR_LEN > `BST_BSR_LONGEST || ISP_AW < 1 || ISP_AW > 32 ||
        ISP_DW < 1 || ISP_DW > 32) begin : g_bad_param
        $error("bst_test_port: unsupported chain lengths");
    end

    typedef struct packed {
        logic [2:0] sy1;
        logic [2:0] sy2;
        logic tck_d;
        bst_tap_state_type st;
        logic [IRL-1:0] ir_sh;
        logic [IRL-1:0] ir;
        logic [BSR_LEN-1:0] dr_sh;
        logic [BSR_LEN-1:0] bsr_up;
        logic [ISP_AW-1:0] isp_addr;
        logic [ISP_DW-1:0] isp_wdata;
        logic isp_mode;
        logic isp_wr;
        logic tdo;
        logic tdo_oe;
    } bst_regs_type;

    localparam bst_regs_type RST = '{st: BST_TLR, ir: IR_DEF, default: '0};

    bst_regs_type r_r;
    bst_regs_type r_nxt;
    logic rise;
    logic fall;
    logic s_tms;
    logic s_tdi;
    bst_dr_sel_type sel;
    int unsigned dr_len;

    // Synchronised pin levels; only the second stage is read
    assign s_tms = r_r.sy2[1];
    assign s_tdi = r_r.sy2[0];
    assign rise = r_r.sy2[2] & ~r_r.tck_d;
    assign fall = ~r_r.sy2[2] & r_r.tck_d;

    // Instruction decode; anything unknown or absent falls to bypass
    always_comb begin
        sel = BST_DR_BYP;
        unique case (r_r.ir)
            `BST_OP_EXTEST, `BST_OP_SAMPLE: sel = BST_DR_BSR;
            `BST_OP_IDCODE: sel = HAS_IDCODE ? BST_DR_ID : BST_DR_BYP;
            `BST_OP_USIG: sel = HAS_USIG ? BST_DR_USIG : BST_DR_BYP;
            `BST_OP_ISP_ADDR: sel = BST_DR_ADDR;
            `BST_OP_ISP_DATA: sel = BST_DR_DATA;
            default: sel = BST_DR_BYP;
        endcase
        unique case (sel)
            BST_DR_ID: dr_len = `BST_ID_LEN;
            BST_DR_USIG: dr_len = `BST_USIG_LEN;
            BST_DR_BSR: dr_len = BSR_LEN;
            BST_DR_ADDR: dr_len = ISP_AW;
            BST_DR_DATA: dr_len = ISP_DW;
            default: dr_len = 1;
        endcase
    end

    // Controller step, shift and update; whole state in one struct
    always_comb begin
        r_nxt = r_r;
        r_nxt.sy1 = {tck, tms, tdi};
        r_nxt.sy2 = r_r.sy1;
        r_nxt.tck_d = r_r.sy2[2];
        r_nxt.isp_wr = 1'b0;
        if (!port_en) begin
            // Pins belong to user logic; hold the controller in reset
            r_nxt.st = BST_TLR;
            r_nxt.ir = IR_DEF;
            r_nxt.tdo_oe = 1'b0;
        end else if (rise) begin
            unique case (r_r.st)
                BST_TLR: r_nxt.st = s_tms ? BST_TLR : BST_RTI;
                BST_RTI: r_nxt.st = s_tms ? BST_SEL_DR : BST_RTI;
                BST_SEL_DR: r_nxt.st = s_tms ? BST_SEL_IR : BST_CAP_DR;
                BST_CAP_DR: r_nxt.st = s_tms ? BST_EX1_DR : BST_SH_DR;
                BST_SH_DR: r_nxt.st = s_tms ? BST_EX1_DR : BST_SH_DR;
                BST_EX1_DR: r_nxt.st = s_tms ? BST_UP_DR : BST_PA_DR;
                BST_PA_DR: r_nxt.st = s_tms ? BST_EX2_DR : BST_PA_DR;
                BST_EX2_DR: r_nxt.st = s_tms ? BST_UP_DR : BST_SH_DR;
                BST_UP_DR: r_nxt.st = s_tms ? BST_SEL_DR : BST_RTI;
                BST_SEL_IR: r_nxt.st = s_tms ? BST_TLR : BST_CAP_IR;
                BST_CAP_IR: r_nxt.st = s_tms ? BST_EX1_IR : BST_SH_IR;
                BST_SH_IR: r_nxt.st = s_tms ? BST_EX1_IR : BST_SH_IR;
                BST_EX1_IR: r_nxt.st = s_tms ? BST_UP_IR : BST_PA_IR;
                BST_PA_IR: r_nxt.st = s_tms ? BST_EX2_IR : BST_PA_IR;
                BST_EX2_IR: r_nxt.st = s_tms ? BST_UP_IR : BST_SH_IR;
                BST_UP_IR: r_nxt.st = s_tms ? BST_SEL_DR : BST_RTI;
                default: r_nxt.st = BST_TLR;
            endcase
            // Capture and shift act in the state left at this edge
            if (r_r.st == BST_CAP_IR) begin
                r_nxt.ir_sh = `BST_IR_CAPTURE;
            end else if (r_r.st == BST_SH_IR) begin
                r_nxt.ir_sh = {s_tdi, r_r.ir_sh[IRL-1:1]};
            end
            if (r_r.st == BST_CAP_DR) begin
                r_nxt.dr_sh = '0;
                unique case (sel)
                    BST_DR_BSR: r_nxt.dr_sh = pin_in;
                    BST_DR_ID: r_nxt.dr_sh[31:0] = ID_WORD;
                    BST_DR_USIG: r_nxt.dr_sh[`BST_USIG_LEN-1:0] = user_signature;
                    BST_DR_ADDR: r_nxt.dr_sh[ISP_AW-1:0] = r_r.isp_addr;
                    BST_DR_DATA: r_nxt.dr_sh[ISP_DW-1:0] = isp_rdata;
                    default: r_nxt.dr_sh[0] = 1'b0;
                endcase
            end else if (r_r.st == BST_SH_DR) begin
                // Serial input enters at the top of the selected length
                for (int i = 0; i < BSR_LEN; i++) begin
                    if (i == dr_len - 1) begin
                        r_nxt.dr_sh[i] = s_tdi;
                    end else if (i < dr_len - 1) begin
                        r_nxt.dr_sh[i] = r_r.dr_sh[i+1];
                    end else begin
                        r_nxt.dr_sh[i] = 1'b0;
                    end
                end
            end
        end else if (fall) begin
            // With the port enabled, the output side changes on the falling edge only
            r_nxt.tdo = (r_r.st == BST_SH_IR) ? r_r.ir_sh[0] : r_r.dr_sh[0];
            r_nxt.tdo_oe = (r_r.st == BST_SH_IR) || (r_r.st == BST_SH_DR);
            if (r_r.st == BST_TLR) begin
                r_nxt.ir = IR_DEF;
            end else if (r_r.st == BST_UP_IR) begin
                r_nxt.ir = r_r.ir_sh;
                if (r_r.ir_sh == `BST_OP_ISP_ENTER) begin
                    r_nxt.isp_mode = 1'b1;
                end else if (r_r.ir_sh == `BST_OP_ISP_EXIT) begin
                    r_nxt.isp_mode = 1'b0;
                end
            end else if (r_r.st == BST_UP_DR) begin
                unique case (sel)
                    BST_DR_BSR: r_nxt.bsr_up = r_r.dr_sh;
                    BST_DR_ADDR: r_nxt.isp_addr = r_r.dr_sh[ISP_AW-1:0];
                    BST_DR_DATA: begin
                        r_nxt.isp_wdata = r_r.dr_sh[ISP_DW-1:0];
                        r_nxt.isp_wr = r_r.isp_mode;
                    end
                    default: r_nxt.isp_wr = 1'b0;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_r <= RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Pin muxing: a disabled port hands every test pin to user logic
    assign tdo_o = port_en ? r_r.tdo : user_tdo_o;
    assign tdo_oe = port_en ? r_r.tdo_oe : user_tdo_oe;
    assign user_pin_in = port_en ? 3'h0 : r_r.sy2;
    assign pin_out = (r_r.ir == `BST_OP_EXTEST) ? r_r.bsr_up : core_out;
    assign isp_mode = r_r.isp_mode;
    assign isp_addr = r_r.isp_addr;
    assign isp_wdata = r_r.isp_wdata;
    assign isp_write = r_r.isp_wr;

    release_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
        !port_en |-> ((tdo_oe == user_tdo_oe) && (tdo_o == user_tdo_o))
        ##1 ((r_r.st == BST_TLR) && (r_r.ir == IR_DEF) && !r_r.tdo_oe))
        else $error("disabled port did not release pins");
    bypass_stage_a: assert property (@(posedge clk) disable iff (!reset_n)
        (port_en && rise && r_r.st == BST_SH_DR && sel == BST_DR_BYP) |=> r_r.dr_sh[0] == $past(s_tdi))
        else $error("bypass stage did not take serial input");
    extest_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        (r_r.ir == `BST_OP_EXTEST) |-> pin_out == r_r.bsr_up)
        else $error("extest not driving boundary pattern");
    normal_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        (r_r.ir == `BST_OP_SAMPLE) |-> pin_out == core_out)
        else $error("sample disturbed normal outputs");
    id_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
        (port_en && rise && r_r.st == BST_CAP_DR && r_r.ir == `BST_OP_IDCODE && HAS_IDCODE)
        |=> (r_r.dr_sh[31:0] == ID_WORD) && r_r.dr_sh[0])
        else $error("identification word not captured");
    usig_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
        (port_en && rise && r_r.st == BST_CAP_DR && sel == BST_DR_USIG)
        |=> r_r.dr_sh[`BST_USIG_LEN-1:0] == $past(user_signature))
        else $error("user signature not captured");
    ir_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
        (port_en && rise && r_r.st == BST_CAP_IR) |=> r_r.ir_sh == `BST_IR_CAPTURE)
        else $error("instruction capture value wrong");
    unknown_op_a: assert property (@(posedge clk) disable iff (!reset_n)
        (r_r.ir[9:8] == 2'b11 && r_r.ir != `BST_OP_BYPASS) |-> sel == BST_DR_BYP && dr_len == 1)
        else $error("unsupported code did not select bypass");
    tdo_on_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
        (port_en && $past(port_en) && $changed(r_r.tdo)) |-> $past(fall))
        else $error("serial output changed off a falling edge");
    isp_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        isp_write |-> (($past(r_r.st) == BST_UP_DR) && $past(fall) && $past(r_r.isp_mode)
        && ($past(r_r.ir) == `BST_OP_ISP_DATA)) ##1 !isp_write)
        else $error("programming write strobe mistimed");
endmodule : bst_test_port

// File: verification/bst_ctrl_model.sv
`timescale 1ns/1ps
// Test controller: tck idles low between frames, tms/tdi change only while tck is low
module bst_ctrl_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One 125 ns period; tdo taken at the rise, long after the device updated it on the fall
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5 tck = 1'b1;
        q = tdo;
        #62.5 tck = 1'b0;
    endtask : step
    // Shift LSB first, tms high on the last bit, then Update and back to idle
    task automatic shift(input int n, input logic [647:0] din, output logic [647:0] dout);
        logic q;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : shift
    task automatic load_ir(input logic [9:0] op, output logic [9:0] cap);
        logic q;
        logic [647:0] o;
        for (int i = 0; i < 4; i++) step(i < 2, 1'b0, q);
        shift(10, {638'h0, op}, o);
        cap = o[9:0];
    endtask : load_ir
    task automatic scan_dr(input int n, input logic [647:0] din, output logic [647:0] dout);
        logic q;
        for (int i = 0; i < 3; i++) step(i == 0, 1'b0, q);
        shift(n, din, dout);
    endtask : scan_dr
    // Five tms-high rises reach Test-Logic-Reset whatever the state, then idle
    task automatic reset_tap;
        logic q;
        for (int i = 0; i < 6; i++) step(i < 5, 1'b0, q);
    endtask : reset_tap
endmodule : bst_ctrl_model

// File: verification/tb.sv
`timescale 1ns/1ps
`include "bst_map.svh"
module tb;
    localparam int BSR = 504;
    localparam logic [31:0] ID_WORD = {4'hA, 16'h1234, 11'h055, 1'b1}; // Arbitrary identity values
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic port_en = 1'b1;
    logic tck, tms, tdi, tdo_o, tdo_oe, isp_mode, isp_write;
    logic user_tdo_o = 1'b0;
    logic user_tdo_oe = 1'b0;
    logic [2:0] user_pin_in;
    logic [BSR-1:0] pin_in = '0;
    logic [BSR-1:0] core_out = '0;
    logic [BSR-1:0] pin_out;
    logic [15:0] isp_addr, isp_wdata;
    logic [15:0] isp_rdata = 16'h0;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int writes = 0;
    always #5 clk = ~clk;
    // Board pull-up: a released serial output reads high at the controller
    bst_ctrl_model u_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo_o : 1'b1));
    bst_test_port #(.BSR_LEN(BSR), .ID_VERSION(4'hA), .ID_PART(16'h1234), .ID_MAKER(11'h055)) u_dut (
        .clk(clk), .reset_n(reset_n), .port_en(port_en), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
        .tdo_oe(tdo_oe), .user_pin_in(user_pin_in), .user_tdo_o(user_tdo_o), .user_tdo_oe(user_tdo_oe),
        .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .user_signature(16'hC3A5),
        .isp_mode(isp_mode), .isp_addr(isp_addr), .isp_wdata(isp_wdata), .isp_write(isp_write),
        .isp_rdata(isp_rdata));
    task automatic check(input logic [647:0] seen, input logic [647:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Cycle ceiling well above the two long boundary scans; also counts write strobes
    // Sampled on the falling edge so the strobe has settled
    always @(negedge clk) begin
        cycles <= cycles + 1;
        if (isp_write === 1'b1) writes <= writes + 1;
        if (cycles == 30000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic t_id;
        logic [647:0] o;
        u_ctrl.reset_tap();
        check(tdo_oe, 1'b0);
        u_ctrl.scan_dr(32, '0, o);
        check(o[31:0], ID_WORD);
        $display("test id done");
    endtask : t_id
    // Documented bypass code and an unassigned code must both give a one-stage path
    task automatic t_byp;
        logic [9:0] c;
        logic [647:0] o;
        logic [9:0] ops [2] = '{`BST_OP_BYPASS, 10'h3C5};
        foreach (ops[k]) begin
            u_ctrl.load_ir(ops[k], c);
            check(c, `BST_IR_CAPTURE);
            u_ctrl.scan_dr(9, 648'h0B5, o);
            check(o[8:0], {8'hB5, 1'b0});
        end
        $display("test bypass done");
    endtask : t_byp
    // One bit past the signature shows the register is exactly sixteen long
    task automatic t_usig;
        logic [9:0] c;
        logic [647:0] o;
        u_ctrl.load_ir(`BST_OP_USIG, c);
        u_ctrl.scan_dr(17, 648'h1, o);
        check(o[16:0], {1'b1, 16'hC3A5});
        $display("test signature done");
    endtask : t_usig
    task automatic t_bsr;
        logic [9:0] c;
        logic [647:0] o;
        @(negedge clk);
        pin_in = {63{8'h96}};
        core_out = {63{8'h3C}};
        u_ctrl.load_ir(`BST_OP_SAMPLE, c);
        u_ctrl.scan_dr(BSR, {144'h0, {63{8'hA5}}}, o);
        check(o[BSR-1:0], {63{8'h96}});
        check(pin_out, {63{8'h3C}});
        @(negedge clk);
        pin_in = {63{8'h69}};
        u_ctrl.load_ir(`BST_OP_EXTEST, c);
        check(pin_out, {63{8'hA5}});
        u_ctrl.scan_dr(BSR, '0, o);
        check(o[BSR-1:0], {63{8'h69}});
        $display("test boundary done");
    endtask : t_bsr
    task automatic t_isp;
        logic [9:0] c;
        logic [647:0] o;
        int w0;
        u_ctrl.load_ir(`BST_OP_ISP_ENTER, c);
        check(isp_mode, 1'b1);
        u_ctrl.load_ir(`BST_OP_ISP_ADDR, c);
        u_ctrl.scan_dr(16, 648'h7E81, o);
        check(isp_addr, 16'h7E81);
        @(negedge clk);
        isp_rdata = 16'h9C63;
        w0 = writes;
        u_ctrl.load_ir(`BST_OP_ISP_DATA, c);
        u_ctrl.scan_dr(16, 648'h1D2E, o);
        check(o[15:0], 16'h9C63);
        check(isp_wdata, 16'h1D2E);
        check(writes - w0, 1);
        u_ctrl.load_ir(`BST_OP_ISP_EXIT, c);
        check(isp_mode, 1'b0);
        $display("test programming done");
    endtask : t_isp
    // Disabled port hands the pins to user logic; tck activity there must be ignored
    task automatic t_release;
        logic q;
        @(negedge clk);
        port_en = 1'b0;
        user_tdo_o = 1'b1;
        user_tdo_oe = 1'b1;
        u_ctrl.step(1'b1, 1'b1, q);
        repeat (4) @(negedge clk);
        check({tdo_o, tdo_oe}, 2'b11);
        check(user_pin_in, 3'b011);
        port_en = 1'b1;
        user_tdo_oe = 1'b0;
        repeat (4) @(negedge clk);
        check(tdo_oe, 1'b0);
        $display("test release done");
    endtask : t_release
    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        t_id();
        t_byp();
        t_usig();
        t_bsr();
        t_isp();
        t_release();
        summarize();
    end
endmodule : tb
